/* File: l1dm_debug_read.sv */
// debug readout of instruction side arrays through the ram select index
`timescale 1ns/10ps
`default_nettype none
module l1dm_debug_read (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic sel_wr_i,
    input wire logic [31:0] sel_data_i,
    output logic [63:0] readout_0_o,
    output logic [63:0] readout_1_o,
    output logic [63:0] readout_2_o
);
    import l1dm_pkg::*;

    typedef struct packed {
        logic [63:0] r0;
        logic [63:0] r1;
        logic [63:0] r2;
    } l1dm_dbg_st_t;

    l1dm_dbg_st_t st;
    l1dm_dbg_st_t next_st;
    logic [63:0] itag_mem [0:(1<<L1DM_DBG_AW)-1];
    logic [63:0] idat_mem [0:(1<<L1DM_DBG_AW)-1];
    logic [63:0] btb_mem [0:(1<<L1DM_DBG_AW)-1];
    logic [7:0] rid;
    logic [L1DM_DBG_AW-1:0] ix;

    // arrays hold a fixed pattern so readout is observable
    for (genvar g = 0; g < (1<<L1DM_DBG_AW); g++) begin : g_init
        assign itag_mem[g] = {56'h0, 8'(g)};
        assign idat_mem[g] = {48'h0, 16'(g) | 16'h0100};
        assign btb_mem[g] = {48'h0, 16'(g) | 16'h0200};
    end

    assign rid = sel_data_i[31:L1DM_RID_LSB];

    // field decode of the select word
    always_comb begin
        ix = '0;
        case (rid)
            L1DM_RID_ITAG: ix = {sel_data_i[19:18], sel_data_i[L1DM_ITAG_IDX_LSB +: 4]};
            L1DM_RID_IDATA: ix = {sel_data_i[19:18], sel_data_i[L1DM_IDATA_IDX_LSB +: 4]};
            L1DM_RID_BTB: ix = sel_data_i[L1DM_BTB_IDX_LSB +: L1DM_DBG_AW];
            default: ix = '0;
        endcase
    end

    // next readout values, loaded in the select cycle
    always_comb begin
        next_st = st;
        if (sel_wr_i) begin
            next_st = '0;
            case (rid)
                L1DM_RID_ITAG: next_st.r0 = itag_mem[ix];
                L1DM_RID_IDATA: next_st.r0 = idat_mem[ix];
                L1DM_RID_BTB: next_st.r0 = btb_mem[ix];
                default: next_st = '0;
            endcase
        end
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign readout_0_o = st.r0;
    assign readout_1_o = st.r1;
    assign readout_2_o = st.r2;
endmodule // l1dm_debug_read
`default_nettype wire

/* File: l1dm_far_model.sv */
// far-side model: answers line fills after a chosen delay
`timescale 1ns/10ps
`default_nettype none
module l1dm_far_model (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire l1dm_pkg::l1dm_down_t down_i,
    input wire logic [3:0] lat_i,
    output logic fill_done_o,
    output logic [63:0] fill_data_o
);
    import l1dm_pkg::*;
    logic [4:0] cnt;
    // data toggles every cycle outside the one answer beat
    always @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            cnt <= 5'h0;
            fill_done_o <= 1'b0;
            fill_data_o <= 64'h0;
        end else begin
            // a new fill request restarts the count and drops the old answer
            fill_done_o <= (cnt == 5'h1) && !(down_i.valid && down_i.fill);
            fill_data_o <= (cnt == 5'h1) ? 64'h0123_4567_89ab_cdef : ~fill_data_o;
            if (down_i.valid && down_i.fill) begin
                cnt <= {1'b0, lat_i} + 5'h1;
            end else if (cnt != 5'h0) begin
                cnt <= cnt - 5'h1;
            end
        end
    end
endmodule // l1dm_far_model
`default_nettype wire

/* File: l1dm_pkg.sv */
// package of constants and carriers for the level-one data memory system
package l1dm_pkg;
    // cache geometry
    localparam int L1DM_WAYS = 4;
    localparam int L1DM_SETS = 16;
    localparam int L1DM_SET_W = 4;
    localparam int L1DM_WAY_W = 2;
    // physical tag covers every address bit above the set index
    localparam int L1DM_TAG_W = 30;
    localparam int L1DM_LINE_LSB = 6;
    localparam int L1DM_ADDR_W = 40;
    localparam logic [39:0] L1DM_LINE_MASK = 40'hff_ffff_ffc0;
    localparam logic [39:0] L1DM_ZERO_BLOCK_BYTES = 40'h00_0000_0040;
    // exclusive granule, sixteen words, log2 of words
    localparam logic [3:0] L1DM_GRANULE_LOG2 = 4'h4;
    localparam logic [3:0] L1DM_RCPC_FIELD = 4'h1;
    localparam int L1DM_RCPC_LSB = 20;
    localparam int L1DM_ERG_LSB = 20;
    // ram select index fields
    localparam int L1DM_RID_LSB = 24;
    localparam int L1DM_WAYF_LSB = 18;
    localparam logic [7:0] L1DM_RID_ITAG = 8'h00;
    localparam logic [7:0] L1DM_RID_IDATA = 8'h01;
    localparam logic [7:0] L1DM_RID_BTB = 8'h02;
    localparam logic [31:0] L1DM_ITAG_MASK = 32'hff0c_3fc0;
    localparam logic [31:0] L1DM_IDATA_MASK = 32'hff0c_3ff8;
    localparam logic [31:0] L1DM_BTB_MASK = 32'hff00_fff0;
    localparam int L1DM_ITAG_IDX_LSB = 6;
    localparam int L1DM_IDATA_IDX_LSB = 3;
    localparam int L1DM_BTB_IDX_LSB = 4;
    localparam int L1DM_DBG_AW = 6;

    // access kinds
    typedef enum logic [7:0] {
        L1DM_OP_LOAD = 8'h01,
        L1DM_OP_STORE = 8'h02,
        L1DM_OP_ATOMIC = 8'h04,
        L1DM_OP_LDEX = 8'h08,
        L1DM_OP_STEX = 8'h10,
        L1DM_OP_CLEAR_EXCLUSIVE = 8'h20,
        L1DM_OP_PREFETCH = 8'h40,
        L1DM_OP_ZERO = 8'h80
    } l1dm_op_t;

    // hardware prefetch sources
    typedef enum logic [1:0] {
        L1DM_PF_NONE = 2'h0,
        L1DM_PF_LOAD = 2'h1,
        L1DM_PF_STORE = 2'h2
    } l1dm_pf_t;

    typedef enum logic [2:0] {
        L1DM_ST_IDLE = 3'h1,
        L1DM_ST_FILL = 3'h2,
        L1DM_ST_RESP = 3'h4
    } l1dm_state_t;

    // request from the core pipeline
    typedef struct packed {
        logic valid;
        l1dm_op_t op;
        logic [39:0] vaddr;
        logic [39:0] paddr;
        logic cacheable;
        logic transient;
        logic non_temporal;
        logic load_atomic;
        logic [63:0] wdata;
    } l1dm_req_t;

    // answer to the core pipeline
    typedef struct packed {
        logic done;
        logic abort;
        logic near;
        logic ex_pass;
        logic [63:0] rdata;
    } l1dm_resp_t;

    // request toward the l2 and interconnect
    typedef struct packed {
        logic valid;
        logic fill;
        logic far_atomic;
        logic evict;
        logic evict_transient;
        logic l2_only;
        logic zero_write;
        logic [39:0] addr;
    } l1dm_down_t;

    // system register access port
    typedef struct packed {
        logic sel_wr;
        logic rd;
        logic [2:0] rd_sel;
        logic [1:0] el;
        logic [31:0] wdata;
    } l1dm_sysreg_t;

    // extended control bits
    typedef struct packed {
        logic near_atomic_try;
        logic load_atomic_near;
    } l1dm_ctl_t;
endpackage

/* File: l1dm_top.sv */
// level-one data memory system: cache, atomics, monitor, prefetch, debug reads
`timescale 1ns/10ps
`default_nettype none
module l1dm_top (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire l1dm_pkg::l1dm_req_t req_i,
    input wire l1dm_pkg::l1dm_pf_t hw_pf_i,
    input wire logic [39:0] hw_pf_addr_i,
    input wire l1dm_pkg::l1dm_ctl_t core_extended_control_i,
    input wire logic ic_far_atomic_i,
    input wire logic line_lost_i,
    input wire logic fill_done_i,
    input wire logic [63:0] fill_data_i,
    input wire l1dm_pkg::l1dm_sysreg_t sysreg_i,
    output l1dm_pkg::l1dm_resp_t resp_o,
    output l1dm_pkg::l1dm_down_t down_o,
    output logic [63:0] sysreg_rdata_o,
    output logic undef_o,
    output logic busy_o
);
    import l1dm_pkg::*;

    // one line per set and way: valid, unique, transient, tag, one data word
    typedef struct packed {
        l1dm_state_t fsm;
        logic [L1DM_WAYS-1:0][L1DM_SETS-1:0] vld;
        logic [L1DM_WAYS-1:0][L1DM_SETS-1:0] uniq;
        logic [L1DM_WAYS-1:0][L1DM_SETS-1:0] trans;
        logic [L1DM_SETS-1:0][L1DM_WAY_W-1:0] victim;
        logic excl;
        logic [39:0] excl_addr;
        l1dm_req_t held;
        logic fill_atomic;
        l1dm_resp_t resp;
        l1dm_down_t down;
        logic [63:0] rdata;
        logic undef;
        logic [31:0] sel;
    } l1dm_st_t;

    l1dm_st_t st;
    l1dm_st_t next_st;
    logic [L1DM_TAG_W-1:0] tag_mem [0:L1DM_WAYS-1][0:L1DM_SETS-1];
    logic [63:0] data_mem [0:L1DM_WAYS-1][0:L1DM_SETS-1];
    logic [L1DM_SET_W-1:0] set_ix;
    logic [L1DM_TAG_W-1:0] tag_in;
    logic [L1DM_WAYS-1:0] hit_vec;
    logic hit;
    logic hit_unique;
    logic [L1DM_WAY_W-1:0] hit_way;
    logic transient_access;
    logic [31:0] ram_select_index;
    logic dbg_wr;
    logic [63:0] ro [0:5];
    logic [L1DM_WAY_W-1:0] vw;
    logic [L1DM_SET_W-1:0] fs;

    // index from virtual, tag from physical address
    function automatic logic [L1DM_SET_W-1:0] set_of(input logic [39:0] va);
        return va[L1DM_LINE_LSB +: L1DM_SET_W];
    endfunction

    function automatic logic [L1DM_TAG_W-1:0] tag_of(input logic [39:0] pa);
        return pa[L1DM_ADDR_W-1 -: L1DM_TAG_W];
    endfunction

    assign set_ix = set_of(req_i.vaddr);
    assign tag_in = tag_of(req_i.paddr);

    // four-way parallel compare
    for (genvar w = 0; w < L1DM_WAYS; w++) begin : g_way
        assign hit_vec[w] = st.vld[w][set_ix] && (tag_mem[w][set_ix] == tag_in);
    end

    always_comb begin
        hit_way = '0;
        for (int w = 0; w < L1DM_WAYS; w++) begin
            if (hit_vec[w]) begin
                hit_way = L1DM_WAY_W'(w);
            end
        end
    end

    assign hit = |hit_vec;
    assign hit_unique = hit && st.uniq[hit_way][set_ix];
    // non-temporal loads fold into the transient path
    assign transient_access = req_i.cacheable && (req_i.transient ||
        (req_i.non_temporal && req_i.op == L1DM_OP_LOAD));

    // privilege check for the debug select instruction
    assign dbg_wr = sysreg_i.sel_wr && (sysreg_i.el == 2'h3);
    // written select word is kept for the data side readouts
    assign ram_select_index = st.sel;

    l1dm_debug_read u_dbg (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .sel_wr_i(dbg_wr),
        .sel_data_i(sysreg_i.wdata),
        .readout_0_o(ro[0]),
        .readout_1_o(ro[1]),
        .readout_2_o(ro[2])
    );

    // data side readouts 3 and 4 show raw stored data and tag bits of the selected line, readout 5 is zero
    assign ro[3] = data_mem[ram_select_index[19:18]][ram_select_index[9:6]];
    assign ro[4] = {34'h0, tag_mem[ram_select_index[19:18]][ram_select_index[9:6]]};
    assign ro[5] = 64'h0;

    assign vw = st.victim[set_of(st.held.vaddr)];
    assign fs = set_of(st.held.vaddr);

    // main next-state logic
    always_comb begin
        next_st = st;
        next_st.resp = '0;
        next_st.down = '0;
        next_st.undef = 1'b0;
        case (st.fsm)
            L1DM_ST_IDLE: begin
                if (req_i.valid) begin
                    next_st.held = req_i;
                    next_st.resp.done = 1'b1;
                    case (req_i.op)
                        L1DM_OP_LOAD, L1DM_OP_STORE, L1DM_OP_LDEX, L1DM_OP_STEX: begin
                            if (req_i.op == L1DM_OP_LDEX) begin
                                next_st.excl = 1'b1;
                                next_st.excl_addr = req_i.paddr & L1DM_LINE_MASK;
                            end
                            if (req_i.op == L1DM_OP_STEX) begin
                                next_st.resp.ex_pass = st.excl &&
                                    ((req_i.paddr & L1DM_LINE_MASK) == st.excl_addr);
                                next_st.excl = 1'b0;
                            end
                            if (hit) begin
                                next_st.resp.rdata = data_mem[hit_way][set_ix];
                            end else if (req_i.cacheable) begin
                                next_st.resp.done = 1'b0;
                                next_st.down.valid = 1'b1;
                                next_st.down.fill = 1'b1;
                                next_st.down.addr = req_i.paddr & L1DM_LINE_MASK;
                                next_st.fsm = L1DM_ST_FILL;
                            end
                        end
                        L1DM_OP_CLEAR_EXCLUSIVE: next_st.excl = 1'b0;
                        L1DM_OP_ATOMIC: begin
                            if (!req_i.cacheable) begin
                                next_st.resp.abort = !ic_far_atomic_i;
                                next_st.down.valid = ic_far_atomic_i;
                                next_st.down.far_atomic = ic_far_atomic_i;
                                next_st.down.addr = req_i.paddr;
                            end else if (hit_unique) begin
                                next_st.resp.near = 1'b1;
                            end else if (core_extended_control_i.near_atomic_try ||
                                (req_i.load_atomic && core_extended_control_i.load_atomic_near)) begin
                                next_st.resp.done = 1'b0;
                                next_st.fill_atomic = 1'b1;
                                next_st.down.valid = 1'b1;
                                next_st.down.fill = 1'b1;
                                next_st.down.addr = req_i.paddr & L1DM_LINE_MASK;
                                next_st.fsm = L1DM_ST_FILL;
                            end else begin
                                next_st.down.valid = 1'b1;
                                next_st.down.far_atomic = 1'b1;
                                next_st.down.addr = req_i.paddr;
                            end
                        end
                        L1DM_OP_PREFETCH: begin
                            if (!hit && req_i.cacheable) begin
                                next_st.down.valid = 1'b1;
                                next_st.down.fill = 1'b1;
                                next_st.down.addr = req_i.paddr & L1DM_LINE_MASK;
                            end
                        end
                        L1DM_OP_ZERO: begin
                            next_st.down.valid = 1'b1;
                            next_st.down.zero_write = 1'b1;
                            next_st.down.addr = req_i.paddr & L1DM_LINE_MASK;
                            if (hit) begin
                                next_st.vld[hit_way][set_ix] = 1'b0;
                            end
                        end
                        default: next_st.resp.done = 1'b1;
                    endcase
                end else if (hw_pf_i != L1DM_PF_NONE) begin
                    // load side fills l1 too, store side l2 only
                    next_st.down.valid = 1'b1;
                    next_st.down.fill = 1'b1;
                    next_st.down.l2_only = (hw_pf_i == L1DM_PF_STORE);
                    next_st.down.addr = hw_pf_addr_i & L1DM_LINE_MASK;
                end
            end
            L1DM_ST_FILL: begin
                if (line_lost_i && st.fill_atomic) begin
                    next_st.down.valid = 1'b1;
                    next_st.down.far_atomic = 1'b1;
                    next_st.down.addr = st.held.paddr;
                    next_st.fill_atomic = 1'b0;
                    next_st.fsm = L1DM_ST_RESP;
                end else if (fill_done_i) begin
                    // eviction of a transient victim passes its hint
                    if (st.vld[vw][fs]) begin
                        next_st.down.valid = 1'b1;
                        next_st.down.evict = 1'b1;
                        next_st.down.evict_transient = st.trans[vw][fs];
                        next_st.down.addr = {tag_mem[vw][fs], fs, 6'h00} & L1DM_LINE_MASK;
                    end
                    next_st.vld[vw][fs] = 1'b1;
                    next_st.uniq[vw][fs] = 1'b1;
                    next_st.trans[vw][fs] = st.held.cacheable && (st.held.transient ||
                        (st.held.non_temporal && st.held.op == L1DM_OP_LOAD));
                    next_st.victim[fs] = vw + 2'h1;
                    next_st.rdata = fill_data_i;
                    next_st.fsm = L1DM_ST_RESP;
                end
            end
            L1DM_ST_RESP: begin
                next_st.resp.done = 1'b1;
                next_st.resp.near = st.fill_atomic;
                next_st.resp.rdata = st.rdata;
                next_st.fill_atomic = 1'b0;
                next_st.fsm = L1DM_ST_IDLE;
            end
            default: next_st.fsm = L1DM_ST_IDLE;
        endcase
        // system register reads
        if (sysreg_i.rd) begin
            next_st.undef = sysreg_i.rd_sel != 3'h7 && sysreg_i.el != 2'h3;
            case (sysreg_i.rd_sel)
                3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5:
                    next_st.rdata = (sysreg_i.el == 2'h3) ? ro[sysreg_i.rd_sel] : 64'h0;
                3'h6: next_st.rdata = 64'(L1DM_RCPC_FIELD) << L1DM_RCPC_LSB;
                default: next_st.rdata = 64'(L1DM_GRANULE_LOG2) << L1DM_ERG_LSB;
            endcase
        end
        if (sysreg_i.sel_wr && sysreg_i.el != 2'h3) begin
            next_st.undef = 1'b1;
        end
        if (dbg_wr) begin
            next_st.sel = sysreg_i.wdata;
        end
    end

    // fill writes into tag and data arrays
    always_ff @(posedge ref_clk_i) begin
        if (st.fsm == L1DM_ST_FILL && fill_done_i && !(line_lost_i && st.fill_atomic)) begin
            tag_mem[vw][fs] <= tag_of(st.held.paddr);
            data_mem[vw][fs] <= fill_data_i;
        end
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            st <= '0;
            st.fsm <= L1DM_ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign resp_o = st.resp;
    assign down_o = st.down;
    assign sysreg_rdata_o = st.rdata;
    assign undef_o = st.undef;
    assign busy_o = (st.fsm != L1DM_ST_IDLE);

    a_near_atomic: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        req_i.valid && req_i.op == L1DM_OP_ATOMIC && req_i.cacheable && hit_unique &&
        st.fsm == L1DM_ST_IDLE |=> resp_o.near && !down_o.far_atomic)
        else $error("unique hit atomic not near");
    a_far_atomic: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        req_i.valid && req_i.op == L1DM_OP_ATOMIC && req_i.cacheable && !hit_unique &&
        !core_extended_control_i.near_atomic_try && !core_extended_control_i.load_atomic_near &&
        st.fsm == L1DM_ST_IDLE |=> down_o.far_atomic)
        else $error("atomic not sent far");
    a_nc_abort: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        req_i.valid && req_i.op == L1DM_OP_ATOMIC && !req_i.cacheable && !ic_far_atomic_i &&
        st.fsm == L1DM_ST_IDLE |=> resp_o.abort && !down_o.valid)
        else $error("unsupported atomic not aborted");
    a_excl_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        req_i.valid && req_i.op == L1DM_OP_CLEAR_EXCLUSIVE && st.fsm == L1DM_ST_IDLE |=> !st.excl)
        else $error("clear exclusive ignored");
    a_pf_retire: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        req_i.valid && req_i.op == L1DM_OP_PREFETCH && st.fsm == L1DM_ST_IDLE |=>
        resp_o.done && st.fsm == L1DM_ST_IDLE)
        else $error("prefetch did not retire");
    a_store_pf_l2: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !req_i.valid && hw_pf_i == L1DM_PF_STORE && st.fsm == L1DM_ST_IDLE |=> down_o.l2_only)
        else $error("store prefetch not l2 only");
    a_zero_align: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        down_o.zero_write |-> (down_o.addr & (L1DM_ZERO_BLOCK_BYTES - 40'h1)) == 40'h0)
        else $error("zero block misaligned");
    a_dbg_undef: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        sysreg_i.sel_wr && sysreg_i.el != 2'h3 |=> undef_o)
        else $error("low level debug select not undefined");
    a_rcpc_field: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        sysreg_i.rd && sysreg_i.rd_sel == 3'h6 |=> sysreg_rdata_o[23:20] == 4'h1)
        else $error("feature field wrong");
    c_fill: cover property (@(posedge ref_clk_i) st.fsm == L1DM_ST_FILL ##1 fill_done_i);
    c_lost: cover property (@(posedge ref_clk_i) st.fill_atomic && line_lost_i);
    c_stex: cover property (@(posedge ref_clk_i) resp_o.ex_pass);
    c_evict_tr: cover property (@(posedge ref_clk_i) down_o.evict_transient);
endmodule // l1dm_top
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the level-one data memory system
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
    $display("Error %0t mismatch", $time); end end
module testbench;
    import l1dm_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    l1dm_req_t req = '0;
    l1dm_pf_t hw_pf = L1DM_PF_NONE;
    logic [39:0] pf_addr = 40'h0;
    l1dm_ctl_t ctl = '0;
    logic ic_far = 1'b0;
    logic lost = 1'b0;
    logic [3:0] lat = 4'h1;
    l1dm_sysreg_t sr = '0;
    l1dm_resp_t resp, rs;
    l1dm_down_t down, dn;
    logic fill_done, undef, busy;
    logic [63:0] fill_data, rdata;
    int err_total = 0;
    int num_checks = 0;
    int wt;
    always #20 ref_clk_i = ~ref_clk_i;
    l1dm_top u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req_i(req), .hw_pf_i(hw_pf),
        .hw_pf_addr_i(pf_addr), .core_extended_control_i(ctl), .ic_far_atomic_i(ic_far),
        .line_lost_i(lost), .fill_done_i(fill_done), .fill_data_i(fill_data), .sysreg_i(sr),
        .resp_o(resp), .down_o(down), .sysreg_rdata_o(rdata), .undef_o(undef), .busy_o(busy));
    l1dm_far_model u_far (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .down_i(down),
        .lat_i(lat), .fill_done_o(fill_done), .fill_data_o(fill_data));
    // one negedge step, with a sticky record of outgoing requests
    task automatic watch();
        @(negedge ref_clk_i);
        if (down.valid === 1'b1) dn = dn | down;
        wt++;
    endtask
    task automatic settle();
        while (busy !== 1'b0 && wt < 60) watch();
    endtask
    task automatic issue(input l1dm_op_t op, input logic [39:0] pa, input logic c, input logic la);
        dn = '0;
        @(posedge ref_clk_i);
        req <= '{valid: 1'b1, op: op, vaddr: pa, paddr: pa, cacheable: c, load_atomic: la,
            default: '0};
        @(posedge ref_clk_i);
        req <= '0;
        wt = 0;
        rs = '0;
        while (rs.done !== 1'b1 && wt < 60) begin
            watch();
            rs = resp;
        end
        `CHK(rs.done, 1'b1)
        settle();
    endtask
    task automatic sys(input logic w, input logic [2:0] sel, input logic [1:0] el);
        @(posedge ref_clk_i);
        sr <= '{sel_wr: w, rd: ~w, rd_sel: sel, el: el, wdata: 32'h0100_0008};
        @(posedge ref_clk_i);
        sr <= '0;
        @(negedge ref_clk_i);
    endtask
    task automatic hwpf(input l1dm_pf_t k);
        dn = '0;
        @(posedge ref_clk_i);
        hw_pf <= k;
        pf_addr <= 40'h55_0000_0080;
        @(posedge ref_clk_i);
        hw_pf <= L1DM_PF_NONE;
        wt = 0;
        repeat (3) watch();
        settle();
    endtask
    task automatic wrap_up();
        if (err_total == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        #400000;
        err_total++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        @(negedge ref_clk_i);
        `CHK({busy, resp.done, down.valid}, 3'h0)
        sys(1'b0, 3'h6, 2'h3);
        `CHK({undef, rdata[23:20]}, 5'h01)
        sys(1'b0, 3'h7, 2'h3);
        `CHK(rdata[23:20], 4'h4)
        sys(1'b0, 3'h3, 2'h1);
        `CHK(undef, 1'b1)
        sys(1'b1, 3'h0, 2'h2);
        `CHK(undef, 1'b1)
        issue(L1DM_OP_ATOMIC, 40'h00_0000_1000, 1'b0, 1'b0);
        `CHK(rs.abort, 1'b1)
        ic_far <= 1'b1;
        issue(L1DM_OP_ATOMIC, 40'h00_0000_1040, 1'b0, 1'b0);
        `CHK({rs.abort, dn.far_atomic}, 2'h1)
        issue(L1DM_OP_ATOMIC, 40'h00_0000_2000, 1'b1, 1'b0);
        `CHK({rs.near, dn.far_atomic}, 2'h1)
        ctl <= '{near_atomic_try: 1'b0, load_atomic_near: 1'b1};
        issue(L1DM_OP_ATOMIC, 40'h00_0000_3000, 1'b1, 1'b1);
        `CHK({rs.near, dn.fill}, 2'h3)
        lost <= 1'b1;
        issue(L1DM_OP_ATOMIC, 40'h00_0000_4000, 1'b1, 1'b1);
        `CHK({rs.near, dn.far_atomic}, 2'h1)
        lost <= 1'b0;
        issue(L1DM_OP_ATOMIC, 40'h00_0000_3000, 1'b1, 1'b0);
        `CHK({rs.near, dn.valid}, 2'h2)
        lat <= 4'h8;
        issue(L1DM_OP_PREFETCH, 40'h00_0000_5000, 1'b1, 1'b0);
        `CHK({dn.fill, wt <= 2}, 2'h3)
        issue(L1DM_OP_ZERO, 40'h12_3456_767f, 1'b1, 1'b0);
        `CHK({dn.zero_write, dn.addr}, {1'b1, 40'h12_3456_7640})
        hwpf(L1DM_PF_STORE);
        `CHK({dn.valid, dn.l2_only}, 2'h3)
        hwpf(L1DM_PF_LOAD);
        `CHK({dn.fill, dn.l2_only}, 2'h2)
        issue(L1DM_OP_LDEX, 40'h00_0000_6000, 1'b1, 1'b0);
        issue(L1DM_OP_STEX, 40'h00_0000_6000, 1'b1, 1'b0);
        `CHK(rs.ex_pass, 1'b1)
        issue(L1DM_OP_LDEX, 40'h00_0000_6000, 1'b1, 1'b0);
        issue(L1DM_OP_CLEAR_EXCLUSIVE, 40'h00_0000_6000, 1'b1, 1'b0);
        issue(L1DM_OP_STEX, 40'h00_0000_6000, 1'b1, 1'b0);
        `CHK(rs.ex_pass, 1'b0)
        sys(1'b1, 3'h0, 2'h3);
        sys(1'b0, 3'h0, 2'h3);
        `CHK(rdata, 64'h0000_0000_0000_0101)
        sys(1'b0, 3'h3, 2'h3);
        `CHK(rdata, 64'h0123_4567_89ab_cdef)
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
